// ### design/diag_pkg.sv
/*
 * Shared constants of the channel diagnosis block: register offsets,
 * selector codes, summary bit positions and interval counts.
 * Assumes a 50 MHz system clock and eight output channels.
 */
package diag_pkg;
	localparam int NCH = 8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int CNT_W = 12;
	localparam int CLK_PERIOD_NS = 20;

	// register byte offsets
	localparam logic [3:0] OFS_FAULT = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_SENSE = 4'h8;
	localparam logic [3:0] OFS_SELECT = 4'hC;
	localparam logic [3:0] OFS_RESULT = 4'h1;
	localparam logic [3:0] OFS_STDDIAG = 4'h2;

	// on_check_selector codes
	localparam logic [3:0] SEL_IDLE = 4'hF;
	localparam logic [3:0] SEL_LOOP = 4'hA;
	localparam logic [3:0] SEL_FIRST = 4'h2;
	localparam logic [3:0] SEL_LAST = 4'h7;
	localparam logic [3:0] FIRST_LOOP_CH = 4'h2;
	localparam logic [3:0] NO_CHAN = 4'h8;

	// standard diagnosis word bit positions
	localparam int STD_OPEN_LOAD_OFF_SUMMARY_BIT = 0;
	localparam int STD_OPEN_LOAD_ON_SUMMARY_BIT = 1;

	// intervals in ns, as specified
	localparam int ON_SETTLE_TIME_NS = 40000;
	localparam int PRE_MUX_WAIT_TIME_NS = 58000;
	localparam int MUX_STEP_TIME_NS = 20000;
	localparam int SYNC_TIME_NS = 1000;

	// interval counts in clock cycles; the pre-mux wait is a least time
	localparam int SETTLE_CYC_I = ON_SETTLE_TIME_NS / CLK_PERIOD_NS;
	localparam int WAIT_CYC_I = (PRE_MUX_WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CYC_I = MUX_STEP_TIME_NS / CLK_PERIOD_NS;
	localparam int SYNC_CYC_I = SYNC_TIME_NS / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(SETTLE_CYC_I > 0 ? SETTLE_CYC_I : 1);
	localparam logic [CNT_W-1:0] WAIT_CYC = CNT_W'(WAIT_CYC_I > 0 ? WAIT_CYC_I : 1);
	localparam logic [CNT_W-1:0] STEP_CYC = CNT_W'(STEP_CYC_I > 0 ? STEP_CYC_I : 1);
	localparam logic [CNT_W-1:0] SYNC_CYC = CNT_W'(SYNC_CYC_I > 0 ? SYNC_CYC_I : 1);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SINGLE,
		ST_DIRECT,
		ST_PWM_ARM,
		ST_PWM_RUN
	} diag_state_t;
endpackage

// ### design/switch_channel_diagnosis.sv
/*
 * Per-channel diagnosis of an eight channel power switch: fault latching,
 * output status sampling, sense current enables and open-load-at-ON checks
 * (single channel or autonomous loop), behind a plain register port.
 * Assumes analog comparator and fault inputs are asynchronous, while channel
 * role and PWM mapping inputs come from logic on the same clock.
 */
// Function
// (R01) fault sets flag, latches off until cleared
// (R02) diagnosis kept strictly per channel
// (R03) status bits sampled live on each read
// (R04) one sense current enable per channel
// (R05) open load never latches channel off
// (R06) host waits settling after sense/state change
// (R07) host reads status while channels off
// (R08) off summary ORs off, sensed status bits
// (R09) on-check only high-side, low current high voltage
// (R10) reset leaves selector idle, checks inactive
// (R11) single channel checked, valid after settling
// (R12) single mode: others zero, refresh on read
// (R13) host keeps channel on before selecting
// (R14) single mode mirrors result into summary
// (R15) loop code starts autonomous check loop
// (R16) host-driven channels first, then PWM ones
// (R17) direct: start channel two, settle/step plus sync
// (R18) direct channel off gives zero result
// (R19) PWM: generator zero first, triggered by on
// (R20) PWM channel off: wait next on phase
// (R21) short PWM on phase gives zero result
// (R22) loop end restores idle, keeps results
// (R23) loop code: summary ORs all results
// (R24) idle code: summary holds last loop
// (R25) reserved codes give zero summary
// (R26) wait pre-mux time after PWM switch-on
// (R27) on-check settling at most forty microseconds
// (R28) mux step at most twenty microseconds
// (R29) intervals counted in clock cycles
`timescale 1ns/10ps
module switch_channel_diagnosis (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [diag_pkg::ADDR_W-1:0] addr_i,
	input wire logic [diag_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [diag_pkg::NCH-1:0] over_load_i,
	input wire logic [diag_pkg::NCH-1:0] over_temp_i,
	input wire logic [diag_pkg::NCH-1:0] status_cmp_i,
	input wire logic [diag_pkg::NCH-1:0] load_cur_low_i,
	input wire logic [diag_pkg::NCH-1:0] out_high_i,
	input wire logic [diag_pkg::NCH-1:0] chan_on_i,
	input wire logic [diag_pkg::NCH-1:0] high_side_i,
	input wire logic [diag_pkg::NCH-1:0] pwm_gen0_i,
	input wire logic [diag_pkg::NCH-1:0] pwm_gen1_i,
	output logic [diag_pkg::DATA_W-1:0] rdata_o,
	output logic [diag_pkg::NCH-1:0] channel_off_o,
	output logic [diag_pkg::NCH-1:0] sense_current_enable_o,
	output logic [3:0] on_check_selector_o
);
	typedef struct packed {
		logic [7:0] ovl_s1;
		logic [7:0] ovl_s2;
		logic [7:0] otp_s1;
		logic [7:0] otp_s2;
		logic [7:0] cmp_s1;
		logic [7:0] cmp_s2;
		logic [7:0] low_s1;
		logic [7:0] low_s2;
		logic [7:0] high_s1;
		logic [7:0] high_s2;
		logic [7:0] on_s1;
		logic [7:0] on_s2;
		logic [7:0] fault;
		logic [7:0] latch_off;
		logic [7:0] osm;
		logic [7:0] sense;
		logic [7:0] open_load_on_summary;
		logic [3:0] sel;
		logic open_load_on_summary_last;
		logic valid;
		logic first;
		logic grp;
		logic [3:0] ch;
		logic [diag_pkg::CNT_W-1:0] cnt;
		diag_pkg::diag_state_t st;
		logic [diag_pkg::DATA_W-1:0] rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	// lowest set channel of mask at or above from, NO_CHAN when none
	function automatic logic [3:0] next_chan(input logic [7:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = diag_pkg::NO_CHAN;
		for (int i = 7; i >= 0; i--) begin
			if (m[i] && (4'(i) >= from)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	logic [7:0] det;
	logic [7:0] direct_mask;
	logic [7:0] gen0_mask;
	logic [7:0] gen1_mask;
	logic [7:0] clr_req;
	logic [7:0] sel_bit;
	logic [diag_pkg::CNT_W-1:0] tgt;
	logic single_code;
	logic rd_std;
	logic rd_res;

	// channel masks; only high-side capable channels take part
	assign det = s_q.low_s2 & s_q.high_s2; // R09
	assign direct_mask = high_side_i & ~(pwm_gen0_i | pwm_gen1_i); // R16
	assign gen0_mask = high_side_i & pwm_gen0_i; // R19
	assign gen1_mask = high_side_i & pwm_gen1_i & ~pwm_gen0_i;
	assign clr_req = (wr_i && addr_i == diag_pkg::OFS_FAULT) ? wdata_i[7:0] : 8'h00;
	assign single_code = (s_q.sel >= diag_pkg::SEL_FIRST) && (s_q.sel <= diag_pkg::SEL_LAST);
	assign sel_bit = 8'h01 << s_q.sel[2:0];
	assign rd_std = rd_i && addr_i == diag_pkg::OFS_STDDIAG;
	assign rd_res = rd_i && addr_i == diag_pkg::OFS_RESULT;

	// interval for the current check step
	always_comb begin
		tgt = diag_pkg::STEP_CYC;
		case (s_q.st)
			// first direct channel pays the settling, later ones the step, each plus the sync time
			diag_pkg::ST_DIRECT: begin
				tgt = s_q.first ? 12'(diag_pkg::SETTLE_CYC + diag_pkg::SYNC_CYC)
					: 12'(diag_pkg::STEP_CYC + diag_pkg::SYNC_CYC); // R17
			end
			// pre-mux wait for the loop's first PWM channel and after a PWM channel was seen off
			diag_pkg::ST_PWM_RUN: begin
				tgt = s_q.first ? 12'(diag_pkg::WAIT_CYC + diag_pkg::STEP_CYC)
					: diag_pkg::STEP_CYC; // R26 R28
			end
			default: tgt = diag_pkg::SETTLE_CYC; // R27
		endcase
	end

	// next state of the whole block
	always_comb begin
		logic [3:0] nx;
		logic [7:0] open_load_on_summary_v;
		logic open_load_off_summary_v;
		logic open_load_on_summary_sum;
		nx = diag_pkg::NO_CHAN;
		open_load_on_summary_v = 8'h00;
		open_load_off_summary_v = 1'b0;
		open_load_on_summary_sum = 1'b0;
		s_d = s_q;
		// two-stage synchronisers for pin-level inputs
		s_d.ovl_s1 = over_load_i;
		s_d.ovl_s2 = s_q.ovl_s1;
		s_d.otp_s1 = over_temp_i;
		s_d.otp_s2 = s_q.otp_s1;
		s_d.cmp_s1 = status_cmp_i;
		s_d.cmp_s2 = s_q.cmp_s1;
		s_d.low_s1 = load_cur_low_i;
		s_d.low_s2 = s_q.low_s1;
		s_d.high_s1 = out_high_i;
		s_d.high_s2 = s_q.high_s1;
		s_d.on_s1 = chan_on_i;
		s_d.on_s2 = s_q.on_s1;
		s_d.rdata = '0;

		// bitwise per channel: no channel touches another; set beats clear
		s_d.fault = (s_q.fault & ~clr_req) | s_q.ovl_s2 | s_q.otp_s2; // R01 R02
		s_d.latch_off = (s_q.latch_off & ~clr_req) | s_q.ovl_s2 | s_q.otp_s2; // R01 R05

		// single channel mode: wait settling, refresh on result or summary read
		if (s_q.st == diag_pkg::ST_SINGLE) begin
			if (s_q.cnt >= tgt) begin
				s_d.valid = 1'b1; // R11
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
			if (s_q.valid && (rd_res || rd_std)) begin
				// a low-side channel has no on-check, so its bit stays zero
				s_d.open_load_on_summary = det & sel_bit & high_side_i; // R09 R12 R14
			end else begin
				s_d.open_load_on_summary = s_q.open_load_on_summary & sel_bit; // R12
			end
		end

		// loop over host-driven channels
		if (s_q.st == diag_pkg::ST_DIRECT) begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt >= tgt) begin
				s_d.open_load_on_summary[s_q.ch[2:0]] = s_q.on_s2[s_q.ch[2:0]] & det[s_q.ch[2:0]]; // R18
				s_d.first = 1'b0;
				s_d.cnt = '0;
				nx = next_chan(direct_mask, s_q.ch + 4'h1);
				if (!nx[3]) begin
					s_d.ch = nx; // R17
				end else begin
					s_d.st = diag_pkg::ST_PWM_ARM; // R16
					s_d.grp = 1'b0;
					s_d.first = 1'b1;
					s_d.ch = next_chan(gen0_mask, 4'h0); // R19
				end
			end
		end

		// PWM channels: wait for on phase, then time the check
		if (s_q.st == diag_pkg::ST_PWM_ARM) begin
			s_d.cnt = '0;
			if (s_q.ch[3]) begin
				if (!s_q.grp) begin
					s_d.grp = 1'b1;
					s_d.ch = next_chan(gen1_mask, 4'h0);
				end else begin
					s_d.st = diag_pkg::ST_IDLE; // R22
					s_d.sel = diag_pkg::SEL_IDLE;
					s_d.open_load_on_summary_last = |s_q.open_load_on_summary;
				end
			end else if (s_q.on_s2[s_q.ch[2:0]]) begin
				s_d.st = diag_pkg::ST_PWM_RUN; // R19
			end else begin
				s_d.first = 1'b1; // R20
			end
		end
		if (s_q.st == diag_pkg::ST_PWM_RUN) begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (!s_q.on_s2[s_q.ch[2:0]] || s_q.cnt >= tgt) begin
				// an on phase that ends early yields zero
				s_d.open_load_on_summary[s_q.ch[2:0]] = s_q.on_s2[s_q.ch[2:0]] & det[s_q.ch[2:0]]; // R21
				s_d.st = diag_pkg::ST_PWM_ARM;
				s_d.first = 1'b0;
				s_d.ch = next_chan(s_q.grp ? gen1_mask : gen0_mask, s_q.ch + 4'h1);
			end
		end

		// summaries as seen at this read
		open_load_off_summary_v = |(s_q.cmp_s2 & ~s_q.on_s2 & s_q.sense); // R08
		if (single_code) begin
			open_load_on_summary_v = (s_q.st == diag_pkg::ST_SINGLE && s_q.valid)
				? (det & sel_bit & high_side_i) : 8'h00; // R09
			open_load_on_summary_sum = |open_load_on_summary_v; // R14
		end else if (s_q.sel == diag_pkg::SEL_LOOP) begin
			open_load_on_summary_sum = |s_q.open_load_on_summary; // R23
		end else if (s_q.sel == diag_pkg::SEL_IDLE) begin
			open_load_on_summary_sum = s_q.open_load_on_summary_last; // R24
		end else begin
			open_load_on_summary_sum = 1'b0; // R25
		end

		// register reads; data stand in the next cycle only
		if (rd_i) begin
			case (addr_i)
				diag_pkg::OFS_FAULT: s_d.rdata[7:0] = s_q.fault;
				diag_pkg::OFS_STATUS: begin
					s_d.rdata[7:0] = s_q.cmp_s2; // R03
					s_d.osm = s_q.cmp_s2;
				end
				diag_pkg::OFS_SENSE: s_d.rdata[7:0] = s_q.sense;
				diag_pkg::OFS_SELECT: s_d.rdata[3:0] = s_q.sel;
				diag_pkg::OFS_RESULT: s_d.rdata[7:0] = single_code ? open_load_on_summary_v : s_q.open_load_on_summary;
				diag_pkg::OFS_STDDIAG: begin
					s_d.rdata[diag_pkg::STD_OPEN_LOAD_OFF_SUMMARY_BIT] = open_load_off_summary_v;
					s_d.rdata[diag_pkg::STD_OPEN_LOAD_ON_SUMMARY_BIT] = open_load_on_summary_sum;
				end
				default: s_d.rdata = '0;
			endcase
		end

		// register writes; a selector write restarts the check logic
		if (wr_i) begin
			case (addr_i)
				diag_pkg::OFS_SENSE: s_d.sense = wdata_i[7:0]; // R04
				diag_pkg::OFS_SELECT: begin
					s_d.sel = wdata_i[3:0];
					s_d.cnt = '0;
					s_d.valid = 1'b0;
					s_d.first = 1'b1;
					s_d.st = diag_pkg::ST_IDLE;
					if (wdata_i[3:0] >= diag_pkg::SEL_FIRST && wdata_i[3:0] <= diag_pkg::SEL_LAST) begin
						s_d.st = diag_pkg::ST_SINGLE; // R11
						s_d.open_load_on_summary = '0;
					end else if (wdata_i[3:0] == diag_pkg::SEL_LOOP) begin
						s_d.open_load_on_summary = '0; // R15
						s_d.grp = 1'b0;
						nx = next_chan(direct_mask, diag_pkg::FIRST_LOOP_CH);
						if (!nx[3]) begin
							s_d.st = diag_pkg::ST_DIRECT; // R16
							s_d.ch = nx;
						end else begin
							s_d.st = diag_pkg::ST_PWM_ARM;
							s_d.ch = next_chan(gen0_mask, 4'h0);
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// state register; reset leaves checks inactive
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_q <= '0;
			s_q.sel <= diag_pkg::SEL_IDLE; // R10
			s_q.st <= diag_pkg::ST_IDLE;
			s_q.ch <= diag_pkg::NO_CHAN;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign channel_off_o = s_q.latch_off;
	assign sense_current_enable_o = s_q.sense;
	assign on_check_selector_o = s_q.sel;

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence loop_running;
		s_q.st != diag_pkg::ST_IDLE && s_q.sel == diag_pkg::SEL_LOOP;
	endsequence
	sequence loop_done;
		s_q.st == diag_pkg::ST_IDLE && !$past(wr_i);
	endsequence

	chk_fault_latch: assert property ( // R01
		(|(s_q.ovl_s2 | s_q.otp_s2)) |=> ((s_q.latch_off & s_q.fault & $past(s_q.ovl_s2 | s_q.otp_s2))
		== $past(s_q.ovl_s2 | s_q.otp_s2))) else $error("fault did not latch channel off");
	chk_latch_hold: assert property ( // R01
		1'b1 |=> ((~s_q.latch_off & $past(s_q.latch_off) & ~$past(clr_req)) == 8'h00))
		else $error("channel released without clear request");
	chk_status_read: assert property ( // R03
		(rd_i && addr_i == diag_pkg::OFS_STATUS) |=> rdata_o[7:0] == $past(s_q.cmp_s2))
		else $error("status read did not show live comparators");
	chk_off_summary: assert property ( // R08
		rd_std |=> rdata_o[diag_pkg::STD_OPEN_LOAD_OFF_SUMMARY_BIT] == |$past(s_q.cmp_s2 & ~s_q.on_s2 & s_q.sense))
		else $error("off summary wrong");
	chk_reset_idle: assert property ( // R10
		$past(srst_i) |-> s_q.sel == diag_pkg::SEL_IDLE && s_q.st == diag_pkg::ST_IDLE)
		else $error("selector not idle after reset");
	chk_single_zero: assert property ( // R12
		s_q.st == diag_pkg::ST_SINGLE |-> (s_q.open_load_on_summary & ~sel_bit) == 8'h00)
		else $error("unselected result bit set");
	chk_loop_end: assert property ( // R22
		loop_running ##1 loop_done |-> s_q.sel == diag_pkg::SEL_IDLE && s_q.open_load_on_summary_last == |s_q.open_load_on_summary)
		else $error("loop end did not restore idle selector");
	chk_step_bound: assert property ( // R17
		s_q.st == diag_pkg::ST_DIRECT |-> s_q.cnt <= tgt)
		else $error("direct check overran its interval");
	chk_pwm_short: assert property ( // R21
		(s_q.st == diag_pkg::ST_PWM_RUN && !s_q.on_s2[s_q.ch[2:0]] && !wr_i)
		|=> s_q.open_load_on_summary[$past(s_q.ch[2:0])] == 1'b0) else $error("short on phase gave nonzero result");
	chk_reserved_zero: assert property ( // R25
		(rd_std && !single_code && s_q.sel != diag_pkg::SEL_LOOP && s_q.sel != diag_pkg::SEL_IDLE)
		|=> rdata_o[diag_pkg::STD_OPEN_LOAD_ON_SUMMARY_BIT] == 1'b0) else $error("reserved code summary not zero");
	// an off PWM channel holds the loop until its next on phase
	chk_pwm_wait: assert property ( // R20
		(s_q.st == diag_pkg::ST_PWM_ARM && !s_q.ch[3] && !s_q.on_s2[s_q.ch[2:0]] && !wr_i)
		|=> s_q.st == diag_pkg::ST_PWM_ARM && s_q.first)
		else $error("loop left an off PWM channel");
	// no single result may be shown before the settling count is done
	chk_single_valid: assert property ( // R11
		(s_q.st == diag_pkg::ST_SINGLE && s_q.cnt < tgt) |-> !s_q.valid)
		else $error("single result valid before settling");
endmodule

// ### verification/host_model.sv
/*
 * Host side of the register port: one-cycle write and read strobes.
 * Assumes the block answers a read in the cycle after the strobe, never stalls.
 */
`timescale 1ns/10ps
module host_model (
	input wire logic clk_i,
	input wire logic [diag_pkg::DATA_W-1:0] rdata_i,
	output logic [diag_pkg::ADDR_W-1:0] addr_o,
	output logic [diag_pkg::DATA_W-1:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	// idle bus from time zero, so no strobe is seen before reset ends
	initial begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// one write cycle; the gap before the next strobe keeps drivers apart
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe; take them at its closing edge
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask
endmodule

// ### verification/switch_channel_diagnosis_tb_top.sv
/*
 * Self-checking bench of the channel diagnosis block: faults, status,
 * sense enables, single on-check, reserved code and the autonomous loop.
 * Assumes the host model drives the register port; the bench drives pins.
 */
`timescale 1ns/10ps
module switch_channel_diagnosis_tb_top;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [7:0] over_load_i = '0;
	logic [7:0] over_temp_i = '0;
	logic [7:0] status_cmp_i = '0;
	logic [7:0] load_cur_low_i = '0;
	logic [7:0] out_high_i = '0;
	logic [7:0] chan_on_i = '0;
	logic [7:0] high_side_i = '0;
	logic [7:0] pwm_gen0_i = '0;
	logic [7:0] pwm_gen1_i = '0;
	logic [7:0] channel_off_o;
	logic [7:0] sense_current_enable_o;
	logic [3:0] on_check_selector_o;
	logic [31:0] rv;
	int num_errors = 0;
	int n_checks = 0;

	// 50 MHz system clock
	always #10 clk_i = ~clk_i;

	switch_channel_diagnosis u_dut (
		.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .over_load_i(over_load_i), .over_temp_i(over_temp_i),
		.status_cmp_i(status_cmp_i), .load_cur_low_i(load_cur_low_i),
		.out_high_i(out_high_i), .chan_on_i(chan_on_i), .high_side_i(high_side_i),
		.pwm_gen0_i(pwm_gen0_i), .pwm_gen1_i(pwm_gen1_i), .rdata_o(rdata),
		.channel_off_o(channel_off_o), .sense_current_enable_o(sense_current_enable_o),
		.on_check_selector_o(on_check_selector_o)
	);

	host_model u_host (
		.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs about 17000 cycles
	initial begin
		cyc(40000);
		num_errors++;
		end_of_test();
	end

	initial begin
		cyc(4);
		srst_i <= 1'b0;
		cyc(3);
		// reset state: selector idle, no results
		u_host.rd(diag_pkg::OFS_SELECT, rv);
		chk(rv, 32'(diag_pkg::SEL_IDLE));
		chk(32'(on_check_selector_o), 32'(diag_pkg::SEL_IDLE));
		u_host.rd(diag_pkg::OFS_RESULT, rv);
		chk(rv, 32'h00000000);
		$display("test reset done");

		// overload on ch3, overtemperature on ch5, then clear one at a time
		over_load_i <= 8'h08;
		over_temp_i <= 8'h20;
		cyc(6);
		over_load_i <= 8'h00;
		over_temp_i <= 8'h00;
		cyc(4);
		chk(32'(channel_off_o), 32'h00000028);
		u_host.rd(diag_pkg::OFS_FAULT, rv);
		chk(rv, 32'h00000028);
		u_host.wr(diag_pkg::OFS_FAULT, 32'h00000008);
		cyc(2);
		chk(32'(channel_off_o), 32'h00000020);
		u_host.rd(diag_pkg::OFS_FAULT, rv);
		chk(rv, 32'h00000020);
		u_host.wr(diag_pkg::OFS_FAULT, 32'h00000020);
		cyc(2);
		chk(32'(channel_off_o), 32'h00000000);
		// a clear while the event still stands is refused: set wins
		over_load_i <= 8'h02;
		cyc(6);
		u_host.wr(diag_pkg::OFS_FAULT, 32'h00000002);
		cyc(2);
		chk(32'(channel_off_o), 32'h00000002);
		over_load_i <= 8'h00;
		cyc(4);
		u_host.wr(diag_pkg::OFS_FAULT, 32'h00000002);
		cyc(2);
		chk(32'(channel_off_o), 32'h00000000);
		$display("test fault done");

		// ch0 on, ch7 off; both comparators report the open condition
		status_cmp_i <= 8'h81;
		chan_on_i <= 8'h01;
		u_host.wr(diag_pkg::OFS_SENSE, 32'h00000081);
		cyc(20);
		chk(32'(sense_current_enable_o), 32'h00000081);
		u_host.rd(diag_pkg::OFS_SENSE, rv);
		chk(rv, 32'h00000081);
		u_host.rd(diag_pkg::OFS_STATUS, rv);
		chk(rv, 32'h00000081);
		u_host.rd(diag_pkg::OFS_STDDIAG, rv);
		chk(rv, 32'h00000001);
		status_cmp_i <= 8'h01;
		cyc(5);
		u_host.rd(diag_pkg::OFS_STATUS, rv);
		chk(rv, 32'h00000001);
		u_host.wr(diag_pkg::OFS_SENSE, 32'h00000001);
		status_cmp_i <= 8'h81;
		cyc(20);
		u_host.rd(diag_pkg::OFS_STDDIAG, rv);
		chk(rv, 32'h00000000);
		chk(32'(channel_off_o), 32'h00000000);
		status_cmp_i <= 8'h00;
		$display("test status done");

		// single channel check on ch4, which is on and open
		high_side_i <= 8'hFC;
		chan_on_i <= 8'hFC;
		load_cur_low_i <= 8'h10;
		out_high_i <= 8'hFF;
		cyc(50);
		u_host.wr(diag_pkg::OFS_SELECT, 32'h00000004);
		cyc(2100);
		chk(32'(on_check_selector_o), 32'h00000004);
		u_host.rd(diag_pkg::OFS_RESULT, rv);
		chk(rv, 32'h00000010);
		u_host.rd(diag_pkg::OFS_STDDIAG, rv);
		chk(rv, 32'h00000002);
		u_host.wr(diag_pkg::OFS_SELECT, 32'h00000003);
		cyc(2100);
		u_host.rd(diag_pkg::OFS_RESULT, rv);
		chk(rv, 32'h00000000);
		u_host.wr(diag_pkg::OFS_SELECT, 32'h00000004);
		cyc(2100);
		// reserved code clears the on summary although ch4 is still open
		u_host.wr(diag_pkg::OFS_SELECT, 32'h00000000);
		cyc(5);
		u_host.rd(diag_pkg::OFS_STDDIAG, rv);
		chk(rv, 32'h00000000);
		$display("test single done");

		// loop: ch2..5 direct with ch4 off, ch7 on generator 0, ch6 on generator 1
		chan_on_i <= 8'hAC;
		load_cur_low_i <= 8'hF8;
		pwm_gen0_i <= 8'h80;
		pwm_gen1_i <= 8'h40;
		cyc(50);
		u_host.wr(diag_pkg::OFS_SELECT, 32'(diag_pkg::SEL_LOOP));
		cyc(3300);
		chk(32'(on_check_selector_o), 32'(diag_pkg::SEL_LOOP));
		u_host.rd(diag_pkg::OFS_STDDIAG, rv);
		chk(rv, 32'h00000002);
		// ch6 stays off well past the ch7 check, so the loop must still wait
		cyc(6500);
		chk(32'(on_check_selector_o), 32'(diag_pkg::SEL_LOOP));
		// an on phase too short for the check gives zero although ch6 is open
		chan_on_i <= 8'hEC;
		cyc(100);
		chan_on_i <= 8'hAC;
		for (int i = 0; i < 12000 && on_check_selector_o !== diag_pkg::SEL_IDLE; i++) begin
			@(posedge clk_i);
		end
		chk(32'(on_check_selector_o), 32'(diag_pkg::SEL_IDLE));
		u_host.rd(diag_pkg::OFS_RESULT, rv);
		chk(rv, 32'h000000A8);
		load_cur_low_i <= 8'h00;
		cyc(20);
		u_host.rd(diag_pkg::OFS_RESULT, rv);
		chk(rv, 32'h000000A8);
		u_host.rd(diag_pkg::OFS_STDDIAG, rv);
		chk(rv, 32'h00000002);
		$display("test loop done");
		end_of_test();
	end
endmodule
